// file: hdl/cfu_config_store.sv
`default_nettype none
// Overview of operation
// - writing 1 to update bit copies all buffer registers into active registers
// - update bit clears itself after the copy
// - 23-byte segment table lists buffer ranges saved to and restored from memory
// - table opcodes: apply-update and end-of-data, interpreted by the controller
// - default table covers every register and ends with an apply-update
// - busy flag reads 1 while a memory transfer runs, 0 when done
// - error flag reads 1 when incorrect data was detected during a transfer
// - restore bit with memory-select pin low reloads settings from memory
// - restore bit clears itself on the cycle after its write
// - write-enable bit 0 (default) refuses memory writes; 1 allows them
// - save bit starts buffer-to-memory transfer, cleared when transfer completes
module cfu_config_store
    import cfu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [CFU_AW-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    input wire logic i_nv_sel_n,
    input wire logic [7:0] i_active_addr,
    output logic [7:0] o_active_data,
    output logic o_nv_we,
    output logic o_nv_re,
    output logic [CFU_NV_AW-1:0] o_nv_addr,
    output logic [7:0] o_nv_wdata,
    input wire logic i_nv_ack,
    input wire logic [7:0] i_nv_rdata,
    output logic o_busy
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic in_table(input logic [CFU_AW-1:0] a);
        return (a >= CFU_TBL_BASE) && (a <= CFU_TBL_LAST);
    endfunction

    function automatic logic in_buffer(input logic [CFU_AW-1:0] a);
        return a <= CFU_BUF_LAST;
    endfunction

    function automatic logic [7:0] flag_byte(input logic f);
        return {7'h00, f};
    endfunction

    logic [7:0] buf_mem [CFU_BUF_DEPTH];
    logic [7:0] act_mem [CFU_BUF_DEPTH];
    logic [7:0] tbl [CFU_TBL_LEN];
    logic wr_enable;
    logic restore_bit;
    logic save_bit;
    logic err_flag;
    logic saving;
    logic apply_pending;
    cfu_state_e state;
    logic [4:0] idx;
    logic [6:0] remain;
    logic [7:0] buf_ptr;
    logic [7:0] sum;
    logic [7:0] cur_entry;
    logic [7:0] next_entry;
    logic host_update;
    logic start_save;
    logic start_restore;
    logic do_apply;
    logic entry_last;
    logic wr_update;
    logic wr_soft;
    logic wr_save;
    logic wr_table;
    logic wr_buffer;
    logic restore_data;
    logic copy_now;

    assign cur_entry = (idx < 5'(CFU_TBL_LEN)) ? tbl[idx] : CFU_OP_END;
    assign entry_last = (idx >= 5'(CFU_TBL_LEN - 1));
    assign next_entry = entry_last ? CFU_OP_END : tbl[idx + 5'h1];
    // host write strobes, decoded once for every concern
    assign wr_update = i_wr_en && (i_addr == CFU_UPDATE_ADDR);
    assign wr_soft = i_wr_en && (i_addr == CFU_SOFT_ADDR);
    assign wr_save = i_wr_en && (i_addr == CFU_SAVE_ADDR);
    assign wr_table = i_wr_en && in_table(i_addr);
    assign wr_buffer = i_wr_en && in_buffer(i_addr);
    assign host_update = wr_update && i_wr_data[CFU_UPDATE_BIT];
    assign start_save = wr_save && i_wr_data[CFU_SAVE_BIT] && wr_enable
        && (state == CFU_ST_IDLE);
    // restore only with memory-select pin low
    assign start_restore = wr_soft && i_wr_data[CFU_RESTORE_BIT] && !i_nv_sel_n
        && (state == CFU_ST_IDLE);
    // apply after a restore only when the checksum matched
    assign do_apply = (state == CFU_ST_SUM_WAIT) && i_nv_ack && apply_pending
        && (saving || (i_nv_rdata == sum));
    assign restore_data = (state == CFU_ST_WAIT) && i_nv_ack && !saving;
    assign copy_now = host_update || do_apply;

    ////////////////////////////////////////////////////////////////////////////
    // segment table, host writable only while idle
    // memory image holds no table: a restore walks the current one
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            // default table covers all and applies
            for (int i = 0; i < CFU_TBL_LEN; i++) begin
                tbl[i] <= CFU_TBL_RESET[i];
            end
        end else if (wr_table && state == CFU_ST_IDLE) begin
            tbl[5'(i_addr - CFU_TBL_BASE)] <= i_wr_data;
        end
    end

    // buffer: restore data wins over the host while a transfer runs
    always_ff @(posedge i_clock) begin
        if (restore_data) begin
            buf_mem[buf_ptr] <= i_nv_rdata;
        end else if (wr_buffer) begin
            buf_mem[8'(i_addr)] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            for (int i = 0; i < CFU_BUF_DEPTH; i++) begin
                act_mem[i] <= 8'h00;
            end
        end else if (copy_now) begin
            for (int i = 0; i < CFU_BUF_DEPTH; i++) begin
                act_mem[i] <= buf_mem[i];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_active_data <= 8'h00;
        end else begin
            o_active_data <= act_mem[i_active_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control bits
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            wr_enable <= 1'b0;
            restore_bit <= 1'b0;
        end else if (wr_soft) begin
            wr_enable <= i_wr_data[CFU_WREN_BIT];
            restore_bit <= i_wr_data[CFU_RESTORE_BIT];
        end else begin
            restore_bit <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            save_bit <= 1'b0;
        end else if (start_save) begin
            save_bit <= 1'b1;
        end else if (state == CFU_ST_SUM_WAIT && i_nv_ack) begin
            // cleared on the checksum ack, the last step of a save
            save_bit <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer engine; one checksum byte follows the data in memory
    // plain 8-bit sum: cheap, but blind to swapped bytes
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state <= CFU_ST_IDLE;
            saving <= 1'b0;
            apply_pending <= 1'b0;
            idx <= 5'h00;
            remain <= 7'h00;
            buf_ptr <= 8'h00;
            sum <= 8'h00;
            o_nv_we <= 1'b0;
            o_nv_re <= 1'b0;
            o_nv_addr <= '0;
            o_nv_wdata <= 8'h00;
        end else begin
            o_nv_we <= 1'b0;
            o_nv_re <= 1'b0;
            case (state)
                CFU_ST_IDLE: begin
                    if (start_save || start_restore) begin
                        state <= CFU_ST_DECODE;
                        saving <= start_save;
                        apply_pending <= 1'b0;
                        idx <= 5'h00;
                        sum <= 8'h00;
                        o_nv_addr <= '0;
                    end
                end
                CFU_ST_DECODE: begin
                    if (cur_entry == CFU_OP_END) begin
                        state <= CFU_ST_SUM;
                    end else if (cur_entry == CFU_OP_APPLY) begin
                        apply_pending <= 1'b1;
                        idx <= idx + 5'h1;
                    end else if (entry_last || cur_entry[CFU_SEG_FLAG_BIT]) begin
                        // odd trailing byte or unknown opcode: stop, never guess a length
                        state <= CFU_ST_SUM;
                    end else begin
                        remain <= cur_entry[6:0];
                        buf_ptr <= next_entry;
                        idx <= idx + 5'h2;
                        state <= CFU_ST_MOVE;
                    end
                end
                CFU_ST_MOVE: begin
                    o_nv_we <= saving;
                    o_nv_re <= !saving;
                    o_nv_wdata <= buf_mem[buf_ptr];
                    state <= CFU_ST_WAIT;
                end
                CFU_ST_WAIT: begin
                    if (i_nv_ack) begin
                        sum <= sum + (saving ? o_nv_wdata : i_nv_rdata);
                        o_nv_addr <= o_nv_addr + 1'b1;
                        buf_ptr <= buf_ptr + 8'h01;
                        if (remain == 7'h00) begin
                            state <= CFU_ST_DECODE;
                        end else begin
                            remain <= remain - 7'h01;
                            state <= CFU_ST_MOVE;
                        end
                    end
                end
                CFU_ST_SUM: begin
                    o_nv_we <= saving;
                    o_nv_re <= !saving;
                    o_nv_wdata <= sum;
                    state <= CFU_ST_SUM_WAIT;
                end
                CFU_ST_SUM_WAIT: begin
                    if (i_nv_ack) begin
                        apply_pending <= 1'b0;
                        state <= CFU_ST_IDLE;
                    end
                end
                default: begin
                    state <= CFU_ST_IDLE;
                end
            endcase
        end
    end

    // checksum mismatch on a restore flags bad data
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            err_flag <= 1'b0;
        end else if (start_save || start_restore) begin
            err_flag <= 1'b0;
        end else if (state == CFU_ST_SUM_WAIT && i_nv_ack) begin
            err_flag <= !saving && (i_nv_rdata != sum);
        end
    end

    // busy while engine not idle
    // raised with the start strobe so a status read right after start sees it
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state != CFU_ST_IDLE) || start_save || start_restore;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read-back, one cycle after i_rd_en
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en) begin
            if (in_buffer(i_addr)) begin
                o_rd_data <= buf_mem[8'(i_addr)];
            end else if (in_table(i_addr)) begin
                o_rd_data <= tbl[5'(i_addr - CFU_TBL_BASE)];
            end else begin
                case (i_addr)
                    // update bit always reads back cleared
                    CFU_UPDATE_ADDR: o_rd_data <= 8'h00;
                    CFU_BUSY_ADDR: o_rd_data <= flag_byte(o_busy);
                    CFU_ERR_ADDR: o_rd_data <= flag_byte(err_flag);
                    CFU_SOFT_ADDR: o_rd_data <= {6'h00, restore_bit, wr_enable};
                    CFU_SAVE_ADDR: o_rd_data <= flag_byte(save_bit);
                    default: o_rd_data <= 8'h00;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// file: hdl/cfu_pkg.sv
`default_nettype none
package cfu_pkg;
    localparam int CFU_AW = 12;
    localparam int CFU_NV_AW = 11;
    localparam int CFU_BUF_DEPTH = 256;
    localparam int CFU_TBL_LEN = 23;

    localparam logic [11:0] CFU_BUF_LAST = 12'h0ff;
    localparam logic [11:0] CFU_UPDATE_ADDR = 12'h232;
    localparam logic [11:0] CFU_TBL_BASE = 12'ha00;
    localparam logic [11:0] CFU_TBL_LAST = 12'ha16;
    localparam logic [11:0] CFU_BUSY_ADDR = 12'hb00;
    localparam logic [11:0] CFU_ERR_ADDR = 12'hb01;
    localparam logic [11:0] CFU_SOFT_ADDR = 12'hb02;
    localparam logic [11:0] CFU_SAVE_ADDR = 12'hb03;

    localparam int CFU_UPDATE_BIT = 0;
    localparam int CFU_WREN_BIT = 0;
    localparam int CFU_RESTORE_BIT = 1;
    localparam int CFU_SAVE_BIT = 0;

    // table entry: data segment is {count-1, start}, bit 7 of first byte clear
    localparam logic [7:0] CFU_OP_APPLY = 8'h80;
    localparam logic [7:0] CFU_OP_END = 8'hff;
    localparam int CFU_SEG_FLAG_BIT = 7;

    localparam logic [7:0] CFU_TBL_RESET [CFU_TBL_LEN] = '{
        8'h7f, 8'h00, 8'h7f, 8'h80, CFU_OP_APPLY, CFU_OP_END,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
    };

    typedef enum logic [2:0] {
        CFU_ST_IDLE = 3'h0,
        CFU_ST_DECODE = 3'h1,
        CFU_ST_MOVE = 3'h3,
        CFU_ST_WAIT = 3'h2,
        CFU_ST_SUM = 3'h6,
        CFU_ST_SUM_WAIT = 3'h7
    } cfu_state_e;
endpackage
`default_nettype wire

// file: verif/cfu_config_store_assertions.sv
`default_nettype none
module cfu_config_store_chk
    import cfu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [CFU_AW-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] o_rd_data,
    input wire logic i_nv_sel_n,
    input wire logic [7:0] i_active_addr,
    input wire logic [7:0] o_active_data,
    input wire logic o_nv_we,
    input wire logic o_nv_re,
    input wire logic [CFU_NV_AW-1:0] o_nv_addr,
    input wire logic [7:0] o_nv_wdata,
    input wire logic i_nv_ack,
    input wire logic [7:0] i_nv_rdata,
    input wire logic o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    logic pend;
    logic req;
    assign req = o_nv_we || o_nv_re;
    // request outstanding until its ack
    always_ff @(posedge i_clock) begin
        if (!i_nrst || i_nv_ack) begin
            pend <= 1'b0;
        end else if (req) begin
            pend <= 1'b1;
        end
    end
    ////////////////////////////////////////
    chk_reset_quiet: assert property ($rose(i_nrst) |-> !o_busy && !req && o_rd_data == 8'h00)
        else $error("outputs not quiet after reset");
    chk_first_req: assert property ($rose(o_busy) |-> ##2 (req && o_nv_addr == 11'h000))
        else $error("first memory request late or not at address zero");
    chk_ack_gap: assert property (i_nv_ack |=> !req)
        else $error("memory request right after ack");
    chk_req_hold: assert property (pend && !req |-> $stable(o_nv_addr) && $stable(o_nv_wdata))
        else $error("memory address or data moved before ack");
    chk_one_dir: assert property (!(o_nv_we && o_nv_re))
        else $error("memory read and write together");
    chk_restore_blocked: assert property (i_wr_en && i_addr == CFU_SOFT_ADDR && i_wr_data[1]
        && i_nv_sel_n && !o_busy |=> !o_busy [*3])
        else $error("restore started with select high");
    chk_restore_runs: assert property (i_wr_en && i_addr == CFU_SOFT_ADDR && i_wr_data[1]
        && !i_nv_sel_n && !o_busy |=> o_busy ##2 o_nv_re)
        else $error("restore did not start");
    chk_busy_reads: assert property (i_rd_en && i_addr == CFU_BUSY_ADDR
        |=> o_rd_data == {7'h00, $past(o_busy)})
        else $error("busy register differs from busy flag");
    chk_update_clears: assert property (i_wr_en && i_addr == CFU_UPDATE_ADDR && i_wr_data[0]
        ##[1:2] i_rd_en && i_addr == CFU_UPDATE_ADDR |=> o_rd_data == 8'h00)
        else $error("update bit not self clearing");
    cover property ($rose(o_busy));
    cover property (i_nv_ack && o_nv_re);
    cover property (o_nv_we && o_nv_addr == 11'h100);
endmodule
bind cfu_config_store cfu_config_store_chk u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .o_rd_data(o_rd_data), .i_nv_sel_n(i_nv_sel_n), .i_active_addr(i_active_addr),
    .o_active_data(o_active_data), .o_nv_we(o_nv_we), .o_nv_re(o_nv_re),
    .o_nv_addr(o_nv_addr), .o_nv_wdata(o_nv_wdata), .i_nv_ack(i_nv_ack),
    .i_nv_rdata(i_nv_rdata), .o_busy(o_busy));
`default_nettype wire

// file: verif/cfu_nv_model.sv
`default_nettype none
module cfu_nv_model
    import cfu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_nv_we,
    input wire logic i_nv_re,
    input wire logic [CFU_NV_AW-1:0] i_nv_addr,
    input wire logic [7:0] i_nv_wdata,
    input wire logic [3:0] i_lat,
    input wire logic i_corrupt,
    output logic o_nv_ack,
    output logic [7:0] o_nv_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [2**CFU_NV_AW];
    logic [3:0] cnt = 4'h0;
    logic rd = 1'b0;
    initial o_nv_ack = 1'b0;
    initial o_nv_rdata = 8'h00;
    ////////////////////////////////////////
    // data only valid in the ack cycle, toggles otherwise
    always @(posedge i_clock) begin
        o_nv_ack <= 1'b0;
        o_nv_rdata <= ~o_nv_rdata;
        if (i_nv_we) begin
            mem[i_nv_addr] <= i_nv_wdata;
        end
        if (i_nv_we || i_nv_re) begin
            cnt <= i_lat;
            rd <= i_nv_re;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                o_nv_ack <= 1'b1;
                if (rd) begin
                    o_nv_rdata <= mem[i_nv_addr] ^ {8{i_corrupt}};
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/test_config_update_and_nv_store.sv
`default_nettype none
module test_config_update_and_nv_store;
    import cfu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_nrst, i_wr_en, i_rd_en, i_nv_sel_n, o_nv_we, o_nv_re, i_nv_ack, o_busy;
    logic [11:0] i_addr;
    logic [7:0] i_wr_data, o_rd_data, i_active_addr, o_active_data, o_nv_wdata, i_nv_rdata, s;
    logic [10:0] o_nv_addr;
    logic [3:0] lat;
    logic corrupt;
    int bad_count = 0;
    int n_tests = 0;
    cfu_config_store u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
        .i_nv_sel_n(i_nv_sel_n), .i_active_addr(i_active_addr), .o_active_data(o_active_data),
        .o_nv_we(o_nv_we), .o_nv_re(o_nv_re), .o_nv_addr(o_nv_addr), .o_nv_wdata(o_nv_wdata),
        .i_nv_ack(i_nv_ack), .i_nv_rdata(i_nv_rdata), .o_busy(o_busy));
    cfu_nv_model u_mem (.i_clock(i_clock), .i_nv_we(o_nv_we), .i_nv_re(o_nv_re),
        .i_nv_addr(o_nv_addr), .i_nv_wdata(o_nv_wdata), .i_lat(lat), .i_corrupt(corrupt),
        .o_nv_ack(i_nv_ack), .o_nv_rdata(i_nv_rdata));
    ////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] q);
        n_tests++;
        if (q !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, q);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_addr = a;
        i_wr_data = d;
        i_wr_en = 1'b1;
        @(negedge i_clock);
        i_wr_en = 1'b0;
        @(negedge i_clock);
    endtask
    task automatic rc(input string n, input logic [11:0] a, input logic [7:0] e);
        i_addr = a;
        i_rd_en = 1'b1;
        @(negedge i_clock);
        i_rd_en = 1'b0;
        chk(n, e, o_rd_data);
        @(negedge i_clock);
    endtask
    task automatic act(input logic [7:0] a, input logic [7:0] e);
        i_active_addr = a;
        repeat (2) @(negedge i_clock);
        chk("active", e, o_active_data);
    endtask
    // host waits for busy low before the next step
    task automatic poll;
        for (int k = 0; k < 3000 && o_busy !== 1'b0; k++) @(negedge i_clock);
        rc("busy", CFU_BUSY_ADDR, 8'h00);
    endtask
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        bad_count++;
        summarize();
    end
    initial begin
        {i_nrst, i_wr_en, i_rd_en, i_addr, i_wr_data, i_active_addr} = '0;
        {i_nv_sel_n, lat, corrupt} = {1'b1, 4'h1, 1'b0};
        repeat (12) @(negedge i_clock);
        i_nrst = 1'b1;
        rc("error", CFU_ERR_ADDR, 8'h00);
        rc("soft", CFU_SOFT_ADDR, 8'h00);
        rc("tbl first", CFU_TBL_BASE, 8'h7f);
        rc("tbl apply", CFU_TBL_BASE + 12'h4, CFU_OP_APPLY);
        rc("tbl end", CFU_TBL_BASE + 12'h5, CFU_OP_END);
        rc("unmapped", 12'h300, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 256; i++) wr(12'(i), 8'(i) ^ 8'h5a);
        wr(CFU_UPDATE_ADDR, 8'h01);
        rc("update", CFU_UPDATE_ADDR, 8'h00);
        act(8'h00, 8'h5a);
        act(8'hff, 8'ha5);
        $display("test update done");
        wr(CFU_SAVE_ADDR, 8'h01);
        rc("save locked", CFU_SAVE_ADDR, 8'h00);
        wr(CFU_SOFT_ADDR, 8'h01);
        wr(CFU_SAVE_ADDR, 8'h01);
        rc("busy run", CFU_BUSY_ADDR, 8'h01);
        poll();
        rc("save clear", CFU_SAVE_ADDR, 8'h00);
        s = 8'h00;
        for (int i = 0; i < 256; i++) s += 8'(i) ^ 8'h5a;
        chk("checksum", s, u_mem.mem[256]);
        chk("image", 8'h4a, u_mem.mem[16]);
        $display("test save done");
        for (int i = 0; i < 256; i++) wr(12'(i), 8'(i));
        wr(CFU_UPDATE_ADDR, 8'h01);
        wr(CFU_SOFT_ADDR, 8'h03);
        rc("busy idle", CFU_BUSY_ADDR, 8'h00);
        i_nv_sel_n = 1'b0;
        lat = 4'h3;
        wr(CFU_SOFT_ADDR, 8'h03);
        poll();
        rc("soft clear", CFU_SOFT_ADDR, 8'h01);
        rc("error", CFU_ERR_ADDR, 8'h00);
        rc("buffer", 12'h010, 8'h4a);
        act(8'h10, 8'h4a);
        $display("test restore done");
        corrupt = 1'b1;
        wr(CFU_SOFT_ADDR, 8'h03);
        poll();
        rc("error", CFU_ERR_ADDR, 8'h01);
        act(8'h10, 8'h4a);
        $display("test error done");
        summarize();
    end
endmodule
`default_nettype wire
